// >>> rtl/bit_shifter.sv
module bit_shifter #(
   parameter int WIDTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [WIDTH-1:0] word_i,
   input wire logic shift_i,
   input wire logic bit_i,
   output logic [WIDTH-1:0] word_o,
   output logic msb_o
);
   logic [WIDTH-1:0] word;
   logic [WIDTH-1:0] next_word;

   // load beats shift, msb leaves first
   always_comb begin
      next_word = word;
      if (rst_i) begin
         next_word = '0;
      end else if (load_i) begin
         next_word = word_i;
      end else if (shift_i) begin
         next_word = {word[WIDTH-2:0], bit_i};
      end
   end

   always_ff @(posedge clk_i) begin
      word <= next_word;
   end

   assign word_o = word;
   assign msb_o = word[WIDTH-1];
endmodule : bit_shifter

// >>> rtl/spi_link_if.sv
interface spi_link_if;
   logic sel_n;
   logic sclk;
   logic mosi;
   logic miso_d;
   logic miso_oe_n;
   logic miso;

   // line pulled high while the device does not drive it
   assign miso = miso_oe_n ? 1'b1 : miso_d;

   modport device (input sel_n, input sclk, input mosi, output miso_d, output miso_oe_n);
   modport host (output sel_n, output sclk, output mosi, input miso);
endinterface : spi_link_if

// >>> rtl/spi_poll_device.sv

`include "spi_poll_regs.svh"

module spi_poll_device (
   input wire logic clk_i,
   input wire logic rst_i,
   spi_link_if.device link,
   output logic access_start_o,
   output spi_poll_pkg::op_t access_op_o,
   input wire logic access_done_i,
   input wire logic [`WORD_BITS-1:0] read_word_i,
   output logic done_o
);
   import spi_poll_pkg::*;

   // ----------------------------------------------------------------------
   // link side, clocked by the serial clock
   // ----------------------------------------------------------------------

   // bits of the frame sampled so far
   logic [5:0] bit_cnt;
   logic [5:0] next_bit_cnt;
   // number of the miso bit driven after this edge
   logic [5:0] out_num;
   // first opcode bit held until the second arrives
   logic op_hi;
   logic next_op_hi;
   logic frame_status;
   logic next_frame_status;
   logic miso_q;
   logic next_miso;
   // persistent across frames
   op_t last_op;
   op_t next_last_op;
   logic start_tgl;
   logic next_start_tgl;
   // completion flag brought over from the system clock
   logic done_meta;
   logic done_sync;
   // word shifter control
   logic load_word;
   logic shift_word;
   logic [`WORD_BITS-1:0] load_value;
   logic word_msb;
   op_t rx_op;

   // ----------------------------------------------------------------------
   // system side, clocked by clk_i
   // ----------------------------------------------------------------------
   logic tgl_meta;
   logic tgl_sync;
   logic tgl_seen;
   logic start_event;
   logic done;
   logic next_done;
   logic [`WORD_BITS-1:0] read_word;
   logic [`WORD_BITS-1:0] next_read_word;
   op_t next_access_op;

   // ----------------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------------

   // opcode completes on the edge that samples bit 3
   assign rx_op = op_t'({op_hi, link.mosi});
   assign out_num = 6'(bit_cnt + 6'h02);

   // frame counter saturates, never wraps inside a long frame
   always_comb begin
      next_bit_cnt = (bit_cnt == 6'h3F) ? bit_cnt : 6'(bit_cnt + 6'h01);
      next_op_hi = op_hi;
      next_frame_status = frame_status;
      if (bit_cnt == 6'(`OP_HI_BIT - 1)) begin
         next_op_hi = link.mosi;
      end
      if (bit_cnt == 6'(`OP_LO_BIT - 1)) begin
         next_frame_status = (rx_op == OP_STATUS);
      end
   end

   // select high clears all frame state except the reply word shifter, new frame counts from zero
   always_ff @(posedge link.sclk or posedge link.sel_n) begin
      if (link.sel_n) begin
         bit_cnt <= 6'h00;
         op_hi <= 1'h0;
         frame_status <= 1'h0;
         miso_q <= 1'h0;
      end else begin
         bit_cnt <= next_bit_cnt;
         op_hi <= next_op_hi;
         frame_status <= next_frame_status;
         miso_q <= next_miso;
      end
   end

   // ----------------------------------------------------------------------
   // last command memory and access launch
   // ----------------------------------------------------------------------

   // any opcode other than status (write, read or reserved) is remembered and starts an access
   always_comb begin
      next_last_op = last_op;
      next_start_tgl = start_tgl;
      if (bit_cnt == 6'(`OP_LO_BIT - 1) && rx_op != OP_STATUS) begin
         next_last_op = rx_op;
         next_start_tgl = ~start_tgl;
      end
   end

   // serial clock is stopped outside frames, so reset acts without it
   always_ff @(posedge link.sclk or posedge rst_i) begin
      if (rst_i) begin
         last_op <= OP_STATUS;
         start_tgl <= 1'h0;
      end else begin
         last_op <= next_last_op;
         start_tgl <= next_start_tgl;
      end
   end

   // flushed by the first frame edges, read only from bit 8 on
   always_ff @(posedge link.sclk) begin
      done_meta <= done;
      done_sync <= done_meta;
   end

   // ----------------------------------------------------------------------
   // reply bits toward the master
   // ----------------------------------------------------------------------

   // word loads as bit 8 leaves, zeros unless a read has finished
   assign load_word = (out_num == 6'(`FLAG_BIT));
   assign load_value = (frame_status && done_sync && last_op == OP_READ) ?
      read_word : '0;
   // shift on the edge that drives each data bit, so d31 leaves first and d0 last
   assign shift_word = (out_num >= 6'(`DATA_FIRST_BIT)) &&
      (out_num <= 6'(`DATA_LAST_BIT));

   bit_shifter #(
      .WIDTH(`WORD_BITS)
   ) reply_word (
      .clk_i(link.sclk),
      .rst_i(1'b0),
      .load_i(load_word),
      .word_i(load_value),
      .shift_i(shift_word),
      .bit_i(1'b0),
      .word_o(),
      .msb_o(word_msb)
   );

   // next miso bit chosen by its frame position
   always_comb begin
      next_miso = 1'h0;
      if (out_num == 6'(`OP_HI_BIT)) begin
         next_miso = last_op[1];
      end else if (out_num == 6'(`OP_LO_BIT)) begin
         next_miso = last_op[0];
      end else if (out_num == 6'(`FLAG_BIT)) begin
         next_miso = frame_status & done_sync;
      end else if (out_num >= 6'(`DATA_FIRST_BIT) && out_num <= 6'(`DATA_LAST_BIT)) begin
         next_miso = word_msb;
      end
   end

   // driver released while select is high
   assign link.miso_d = miso_q;
   assign link.miso_oe_n = link.sel_n;

   // ----------------------------------------------------------------------
   // system side: access start, completion flag, read word
   // ----------------------------------------------------------------------

   assign start_event = tgl_sync ^ tgl_seen;

   // set by completion wins over clear by a new start
   always_comb begin
      next_done = done;
      next_read_word = read_word;
      next_access_op = access_op_o;
      if (start_event) begin
         next_done = 1'h0;
         next_access_op = last_op;
      end
      if (access_done_i) begin
         next_done = 1'h1;
         if (access_op_o == OP_READ) begin
            next_read_word = read_word_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      tgl_meta <= start_tgl;
      tgl_sync <= tgl_meta;
      if (rst_i) begin
         tgl_seen <= tgl_sync;
         done <= `DONE_RESET;
         read_word <= '0;
         access_op_o <= OP_STATUS;
         access_start_o <= 1'h0;
      end else begin
         tgl_seen <= tgl_sync;
         done <= next_done;
         read_word <= next_read_word;
         access_op_o <= next_access_op;
         access_start_o <= start_event;
      end
   end

   assign done_o = done;
endmodule : spi_poll_device

// >>> rtl/spi_poll_master.sv
`include "spi_poll_regs.svh"

module spi_poll_master #(
   parameter int HALF = `HALF_SCLK,
   parameter int GAP = `IDLE_GAP
) (
   input wire logic clk_i,
   input wire logic rst_i,
   spi_link_if.host link,
   input wire logic cmd_valid_i,
   input wire spi_poll_pkg::op_t cmd_op_i,
   output logic cmd_ready_o,
   output logic reply_valid_o,
   output spi_poll_pkg::op_t reply_op_o,
   output logic reply_flag_o,
   output logic [`WORD_BITS-1:0] reply_word_o
);
   import spi_poll_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   master_state_t state;
   master_state_t next_state;
   logic [7:0] tmr;
   logic [7:0] next_tmr;
   logic [5:0] bitn;
   logic [5:0] next_bitn;
   op_t op;
   op_t next_op;
   logic sel_n;
   logic next_sel_n;
   logic sclk;
   logic next_sclk;
   logic mosi;
   logic next_mosi;
   logic reply;
   logic next_reply;
   logic miso_meta;
   logic miso_sync;
   logic capture;
   logic [`FRAME_BITS-1:0] frame;

   // mosi value for frame bit n, only the opcode carries meaning
   function automatic logic mosi_bit(input op_t o, input logic [5:0] n);
      logic b;
      b = 1'b0;
      if (n == 6'(`OP_HI_BIT)) begin
         b = o[1];
      end else if (n == 6'(`OP_LO_BIT)) begin
         b = o[0];
      end
      return b;
   endfunction : mosi_bit

   // ----------------------------------------------------------------------
   // miso pin synchroniser and frame capture
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      miso_meta <= link.miso;
      miso_sync <= miso_meta;
   end

   assign capture = (state == M_LOW) && (tmr == 8'h00);

   bit_shifter #(
      .WIDTH(`FRAME_BITS)
   ) capture_word (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(1'b0),
      .word_i('0),
      .shift_i(capture),
      .bit_i(miso_sync),
      .word_o(frame),
      .msb_o()
   );

   // ----------------------------------------------------------------------
   // frame sequencer, serial clock divided from clk_i
   // ----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_tmr = (tmr == 8'h00) ? 8'h00 : 8'(tmr - 8'h01);
      next_bitn = bitn;
      next_op = op;
      next_sel_n = sel_n;
      next_sclk = sclk;
      next_mosi = mosi;
      next_reply = 1'h0;
      unique case (state)
         M_IDLE: begin
            if (cmd_valid_i) begin
               next_op = cmd_op_i;
               next_sel_n = 1'h0;
               next_bitn = 6'h00;
               next_mosi = mosi_bit(cmd_op_i, 6'h01);
               next_tmr = 8'(HALF - 1);
               next_state = M_LOW;
            end
         end
         M_LOW: begin
            if (tmr == 8'h00) begin
               next_sclk = 1'h1;
               next_bitn = 6'(bitn + 6'h01);
               next_tmr = 8'(HALF - 1);
               next_state = M_HIGH;
            end
         end
         M_HIGH: begin
            if (tmr == 8'h00) begin
               next_sclk = 1'h0;
               next_tmr = 8'(HALF - 1);
               if (bitn == 6'(`FRAME_BITS)) begin
                  next_mosi = 1'h0;
                  next_state = M_HOLD;
               end else begin
                  next_mosi = mosi_bit(op, 6'(bitn + 6'h01));
                  next_state = M_LOW;
               end
            end
         end
         M_HOLD: begin
            if (tmr == 8'h00) begin
               next_sel_n = 1'h1;
               next_tmr = 8'(GAP - 1);
               next_state = M_GAP;
            end
         end
         M_GAP: begin
            if (tmr == 8'h00) begin
               if (frame[`FRAME_BITS-`FLAG_BIT] == 1'b0) begin
                  // still pending: poll again with a status command
                  next_op = OP_STATUS;
                  next_sel_n = 1'h0;
                  next_bitn = 6'h00;
                  next_mosi = 1'h0;
                  next_tmr = 8'(HALF - 1);
                  next_state = M_LOW;
               end else begin
                  next_reply = 1'h1;
                  next_state = M_IDLE;
               end
            end
         end
         default: begin
            next_state = M_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= M_IDLE;
         tmr <= 8'h00;
         bitn <= 6'h00;
         op <= OP_STATUS;
         sel_n <= 1'h1;
         sclk <= 1'h0;
         mosi <= 1'h0;
         reply <= 1'h0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         bitn <= next_bitn;
         op <= next_op;
         sel_n <= next_sel_n;
         sclk <= next_sclk;
         mosi <= next_mosi;
         reply <= next_reply;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign link.sel_n = sel_n;
   assign link.sclk = sclk;
   assign link.mosi = mosi;
   assign cmd_ready_o = (state == M_IDLE);
   assign reply_valid_o = reply;
   assign reply_op_o = op_t'(frame[`FRAME_BITS-`OP_HI_BIT -: 2]);
   assign reply_flag_o = frame[`FRAME_BITS-`FLAG_BIT];
   assign reply_word_o = frame[`WORD_BITS-1:0];
endmodule : spi_poll_master

// >>> rtl/spi_poll_pkg.sv
package spi_poll_pkg;

   // ----------------------------------------------------------------------
   // command opcodes carried in frame bits 2 and 3
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_STATUS = 2'b00,
      OP_WRITE = 2'b01,
      OP_READ = 2'b10,
      OP_RSVD = 2'b11
   } op_t;

   // ----------------------------------------------------------------------
   // master sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_LOW = 3'b001,
      M_HIGH = 3'b010,
      M_HOLD = 3'b011,
      M_GAP = 3'b100
   } master_state_t;

endpackage : spi_poll_pkg

// >>> rtl/spi_poll_regs.svh
`ifndef SPI_POLL_REGS_SVH
`define SPI_POLL_REGS_SVH

// ----------------------------------------------------------------------
// frame layout, bit numbers count from 1 at the first serial clock
// ----------------------------------------------------------------------
`define FRAME_BITS 40
`define OP_HI_BIT 2
`define OP_LO_BIT 3
`define FLAG_BIT 8
`define DATA_FIRST_BIT 9
`define DATA_LAST_BIT 40
`define WORD_BITS 32

// ----------------------------------------------------------------------
// reset values and timing counts in system clocks
// ----------------------------------------------------------------------
`define DONE_RESET 1'h1
`define HALF_SCLK 4
`define IDLE_GAP 4

`endif

// >>> sim/spi_status_poll_command_checker.sv
`include "spi_poll_regs.svh"

module spi_status_poll_command_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sel_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso_d,
   input wire logic miso_oe_n,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   import spi_poll_pkg::*;

   logic [5:0] rises, next_rises;
   logic [1:0] frame_op, next_frame_op, last_op, next_last_op;
   logic flag, next_flag, sclk_q, rise;

   // ----------------------------------------------------------------------
   // frame tracking
   // ----------------------------------------------------------------------
   assign rise = sclk & ~sclk_q;

   // count rises, collect opcode and flag, remember last access opcode
   always_comb begin
      next_rises = rises;
      next_frame_op = frame_op;
      next_last_op = last_op;
      next_flag = flag;
      if (sel_n) begin
         next_rises = '0;
         next_frame_op = '0;
         if (rises == 6'(`FRAME_BITS) && frame_op != OP_STATUS) begin
            next_last_op = frame_op;
         end
      end else if (rise) begin
         next_rises = rises + 6'h01;
         if (rises == 6'h01 || rises == 6'h02) begin
            next_frame_op = {frame_op[0], mosi};
         end
         if (rises == 6'h06) begin
            next_flag = miso;
         end
      end
   end

   // register the tracking state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rises <= '0;
         frame_op <= '0;
         last_op <= '0;
         flag <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         rises <= next_rises;
         frame_op <= next_frame_op;
         last_op <= next_last_op;
         flag <= next_flag;
         sclk_q <= sclk;
      end
   end

   // ----------------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_OE_IDLE: assert property (miso_oe_n == sel_n)
      else $error("miso enable differs from select");
   AST_RELEASE: assert property (sel_n |-> miso && !miso_d)
      else $error("miso line not released outside a frame");
   AST_SCLK_IDLE: assert property (sel_n |-> !sclk)
      else $error("serial clock moves outside a frame");
   AST_FRAME_LEN: assert property ($rose(sel_n) |-> rises == 6'(`FRAME_BITS))
      else $error("frame length is not forty clocks");
   AST_GAP: assert property ($rose(sel_n) |-> sel_n[*4])
      else $error("select not released between frames");
   AST_FIRST_EDGE: assert property ($fell(sel_n) |-> !sclk[*4] ##1 sclk)
      else $error("first serial edge misplaced after select");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
      else $error("serial clock high phase wrong");
   AST_MOSI_STABLE: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("mosi changes while serial clock high");
   AST_ECHO: assert property (rise && !sel_n && rises <= 6'h01 |->
      miso == (rises == 6'h00 ? last_op[1] : last_op[0]))
      else $error("echoed opcode differs from last access");
   AST_FILLER: assert property (rise && !sel_n && rises >= 6'h07 && rises <= 6'h26 &&
      !(frame_op == OP_STATUS && flag && last_op == OP_READ) |-> !miso)
      else $error("filler bits carry data");

   // main scenarios
   cover property (rise && rises == 6'h06 && frame_op == OP_STATUS && !miso);
   cover property ($rose(sel_n) && frame_op == OP_STATUS && flag && last_op == OP_READ);
   cover property ($rose(sel_n) && frame_op == OP_WRITE);
endmodule : spi_status_poll_command_checker

// >>> sim/spi_status_poll_command_tb.sv
`include "spi_poll_regs.svh"

module spi_status_poll_command_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import spi_poll_pkg::*;

   typedef struct {
      op_t op;
      logic [`WORD_BITS-1:0] word;
   } reply_exp_t;

   localparam int LIMIT = 40000;
   logic clk_i = 1'b0, rst_i = 1'b0, cmd_valid = 1'b0, access_done = 1'b0;
   logic cmd_ready, reply_valid, reply_flag, access_start, done_flag;
   op_t cmd_op = OP_STATUS, exp_op = OP_STATUS, reply_op, access_op;
   logic [`WORD_BITS-1:0] reply_word, read_word = '0;
   logic [31:0] rnd = 32'hA0C798F6;
   op_t plan [8] = '{OP_STATUS, OP_WRITE, OP_STATUS, OP_READ, OP_READ, OP_STATUS, OP_WRITE,
      OP_STATUS};
   reply_exp_t reply_q[$];
   op_t start_q[$];
   int err_count = 0, compares = 0, replies = 0, cycles = 0;

   // ----------------------------------------------------------------------
   // both ends joined by the link
   // ----------------------------------------------------------------------
   spi_link_if link ();

   spi_poll_master i_spi_poll_master (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_ready_o(cmd_ready),
      .reply_valid_o(reply_valid), .reply_op_o(reply_op), .reply_flag_o(reply_flag),
      .reply_word_o(reply_word));

   spi_poll_device i_spi_poll_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .access_start_o(access_start), .access_op_o(access_op), .access_done_i(access_done),
      .read_word_i(read_word), .done_o(done_flag));

   spi_status_poll_command_checker i_spi_status_poll_command_checker (.clk_i(clk_i),
      .rst_i(rst_i), .sel_n(link.sel_n), .sclk(link.sclk), .mosi(link.mosi),
      .miso_d(link.miso_d), .miso_oe_n(link.miso_oe_n), .miso(link.miso));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   always #12.5 clk_i = ~clk_i;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr_next

   task automatic fail(input string what, input logic [31:0] exp, input logic [31:0] got);
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
   endtask : fail

   task automatic check_reply(input reply_exp_t e);
      compares++;
      if (reply_op !== e.op) fail("reply opcode", 32'(e.op), 32'(reply_op));
      if (reply_flag !== 1'b1) fail("reply flag", 32'h1, 32'(reply_flag));
      if (reply_word !== e.word) fail("reply word", e.word, reply_word);
   endtask : check_reply

   task automatic check_start(input op_t e);
      compares++;
      if (access_op !== e) fail("access opcode", 32'(e), 32'(access_op));
   endtask : check_start

   task automatic check_done(input logic e);
      compares++;
      if (done_flag !== e) fail("completion level", 32'(e), 32'(done_flag));
   endtask : check_done

   task automatic check_ready();
      compares++;
      if (cmd_ready !== 1'b1) fail("command ready", 32'h1, 32'(cmd_ready));
   endtask : check_ready

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // issue one command, note its expected reply, wait for the reply
   task automatic send(input op_t op);
      reply_exp_t e;
      int n;
      @(negedge clk_i);
      check_ready();
      rnd = lfsr_next(rnd);
      if (op == OP_READ) read_word = rnd;
      if (op != OP_STATUS) begin
         start_q.push_back(op);
         exp_op = op;
      end
      e.op = exp_op;
      e.word = (exp_op == OP_READ) ? read_word : '0;
      reply_q.push_back(e);
      n = replies;
      cmd_op = op;
      cmd_valid = 1'b1;
      @(negedge clk_i);
      cmd_valid = 1'b0;
      for (int i = 0; i < 20000 && replies == n; i++) @(posedge clk_i);
      if (replies == n) fail("reply timeout", 32'(n + 1), 32'(replies));
      $display("test %0d opcode %0d done", replies, op);
   endtask : send

   // ----------------------------------------------------------------------
   // watchers
   // ----------------------------------------------------------------------
   // compare each reply with the oldest note
   always @(negedge clk_i) begin
      if (!rst_i && reply_valid === 1'b1) begin
         replies++;
         if (reply_q.size() == 0) fail("unexpected reply", 32'h0, 32'h1);
         else check_reply(reply_q.pop_front());
      end
   end

   // user side of the device: check the start, finish after a random delay
   initial begin : responder
      int dly;
      forever begin
         @(negedge clk_i);
         if (access_start === 1'b1) begin
            if (start_q.size() == 0) fail("unexpected access start", 32'h0, 32'h1);
            else check_start(start_q.pop_front());
            check_done(1'b0);
            rnd = lfsr_next(rnd);
            dly = (rnd[4] ? 3 : 400) + int'(rnd[7:0]);
            repeat (dly) @(negedge clk_i);
            access_done = 1'b1;
            @(negedge clk_i);
            access_done = 1'b0;
            @(negedge clk_i);
            check_done(1'b1);
         end
      end
   end

   // cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         $display("CHECK FAILED cycle limit expected %0d seen %0d", replies + 1, replies);
         print_verdict();
      end
   end

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      // a real rising reset edge clears the serial side, whose clock is still
      #1 rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      foreach (plan[i]) send(plan[i]);
      repeat (20) @(negedge clk_i);
      if (start_q.size() != 0) fail("missing access start", 32'h0, 32'(start_q.size()));
      print_verdict();
   end
endmodule : spi_status_poll_command_tb
